// *** src/tcc_pkg.sv ***
// package for the timer control block: offsets, fields, reset values, types
// assumes a 32-bit AXI4-Lite register bus and one 200 MHz clock
package tcc_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL_ONE = 8'h00;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h04;
   localparam logic [7:0] OFS_ARR      = 8'h08;
   localparam logic [7:0] OFS_EVENT    = 8'h0C;
   localparam logic [7:0] OFS_STATUS   = 8'h10;

   localparam logic [15:0] CTRL_ONE_RESET = 16'h0000;
   localparam logic [15:0] CTRL_TWO_RESET = 16'h0000;
   localparam logic [15:0] ARR_RESET      = 16'hFFFF;

   // writable bit masks; everything else stays zero
   localparam logic [15:0] CTRL_ONE_MASK = 16'h03FF;
   localparam logic [15:0] CTRL_TWO_MASK = 16'h00F8;

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int F_RUN   = 0;
   localparam int F_UINH  = 1;
   localparam int F_USRC  = 2;
   localparam int F_SPUL  = 3;
   localparam int F_DIR   = 4;
   localparam int F_CMS   = 5;
   localparam int F_RELOAD_BUFFER_ENABLE  = 7;
   localparam int F_CKD   = 8;
   localparam int F_CHANNEL_REQUEST_TIMING  = 3;
   localparam int F_MMS   = 4;
   localparam int F_INPUT_ONE_XOR_SELECT  = 7;
   localparam int F_UG    = 0;

   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // ----------------------------------------------------------------
   // types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MMS_RESET, MMS_ENABLE, MMS_UPDATE, MMS_PULSE,
      MMS_OC1, MMS_OC2, MMS_OC3, MMS_OC4
   } tcc_mms_t;

   typedef enum logic [2:0] {
      SLV_OFF, SLV_ENC1, SLV_ENC2, SLV_ENC3,
      SLV_RESET, SLV_GATED, SLV_TRIGGER, SLV_EXTCLK
   } tcc_slave_t;

   typedef struct packed {
      logic [1:0] filter_clock_divide;
      logic       reload_buffer_enable;
      logic [1:0] centre_align_select;
      logic       dir;
      logic       spul;
      logic       usrc;
      logic       uinh;
      logic       run;
   } tcc_ctrl_one_t;

   typedef struct packed {
      logic       input_one_xor_select;
      tcc_mms_t   master_output_select;
      logic       channel_request_timing;
   } tcc_ctrl_two_t;

   typedef struct packed {
      logic       cc1Event;
      logic [3:0] ocRef;
      logic [2:0] ch;
   } tcc_chan_t;

endpackage

// *** src/tcc_timer_control.sv ***
// control section of a 16-bit timer with trigger output to slave timers
// assumes channels and slave controller sit outside on clock; the counter core is in this block
//
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// What this block does
// - filter sample tick from clock divide field
// - reload value direct or buffered till update
// - edge-aligned counts by direction bit
// - centre modes alternate; compare flags per direction
// - direction bit read-only, shows direction in centre
// - single pulse clears run at update
// - update source selects update request causes
// - update event loads shadow registers
// - inhibit blocks update, generate still reinitialises
// - run set by software; trigger mode sets it
// - upper six bits of register one read zero
// - input one is pin one or xor
// - code 000 drives generate onto trigger output
// - code 001 drives counter enable signal
// - code 010 drives update event
// - code 011 pulses on channel one event
// - codes 100-111 drive compare references
// - channel requests on channel or update event
// - half-word and word accesses accepted
// - low three bits of register two read zero
// - gated mode counts only while trigger high
// - trigger mode starts counter on rising edge
module tcc_timer_control #(
   parameter int CNT_WIDTH = 16
) (
   // clock and reset
   input  wire logic                 clock,
   input  wire logic                 srst,
   // axi4-lite write
   input  wire logic [7:0]           s_axi_awaddr,
   input  wire logic                 s_axi_awvalid,
   output var  logic                 s_axi_awready,
   input  wire logic [31:0]          s_axi_wdata,
   input  wire logic [3:0]           s_axi_wstrb,
   input  wire logic                 s_axi_wvalid,
   output var  logic                 s_axi_wready,
   output var  logic [1:0]           s_axi_bresp,
   output var  logic                 s_axi_bvalid,
   input  wire logic                 s_axi_bready,
   // axi4-lite read
   input  wire logic [7:0]           s_axi_araddr,
   input  wire logic                 s_axi_arvalid,
   output var  logic                 s_axi_arready,
   output var  logic [31:0]          s_axi_rdata,
   output var  logic [1:0]           s_axi_rresp,
   output var  logic                 s_axi_rvalid,
   input  wire logic                 s_axi_rready,
   // pins and neighbouring logic
   input  wire logic [2:0]           chPin,
   input  wire tcc_pkg::tcc_chan_t   chan,
   input  wire tcc_pkg::tcc_slave_t  slaveMode,
   input  wire logic                 triggerInput,
   input  wire logic                 masterSlaveSync,
   input  wire logic                 slaveUpdate,
   // outputs
   output var  logic                 triggerOutput,
   output var  logic                 timerInputOne,
   output var  logic                 filterTick,
   output var  logic                 counterEnableSignal,
   output var  logic [CNT_WIDTH-1:0] counterValue,
   output var  logic                 updateEvent,
   output var  logic                 updateRequest,
   output var  logic                 chanRequest,
   output var  logic                 compareFlagEnable
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   tcc_pkg::tcc_ctrl_one_t ctlOne_q;
   tcc_pkg::tcc_ctrl_two_t ctlTwo_q;
   logic [15:0] arrPre_q;
   logic [15:0] arrShadow_q;
   logic [CNT_WIDTH-1:0] cnt_q;
   logic        downNow_q;
   logic        ugPulse_q;
   logic [2:0]  pinSync1_q;
   logic [2:0]  pinSync2_q;
   logic        trigSync1_q;
   logic        trigSync2_q;
   logic        trigPrev_q;
   logic [1:0]  divCnt_q;
   logic        trigDly_q;

   // bus state
   logic        awHeld_q;
   logic        wHeld_q;
   logic [7:0]  awAddr_q;
   logic [31:0] wData_q;
   logic [3:0]  wStrb_q;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] data,
                                           input logic [3:0]  strb,
                                           input logic [15:0] mask);
      logic [15:0] res;
      res = old;
      if (strb[0]) res[7:0] = data[7:0];
      if (strb[1]) res[15:8] = data[15:8];
      return res & mask;
   endfunction

   function automatic logic halfOrWord(input logic [3:0] strb);
      return (strb == 4'h3) || (strb == 4'hF) || (strb == 4'hC);
   endfunction

   // ----------------------------------------------------------------
   // write channel
   // ----------------------------------------------------------------
   logic wrGo;
   logic wrOk;
   logic wrOne;
   logic wrTwo;
   logic wrArr;
   logic wrEvt;
   logic centreMode;
   logic readOnlyDir;
   logic swUpdate;
   logic overflow;
   logic cntStep;
   logic rawUpdate;
   logic trigRise;
   logic [15:0] oneMerged;
   logic [15:0] twoMerged;

   assign wrGo  = awHeld_q && wHeld_q && !s_axi_bvalid;
   assign wrOk  = halfOrWord(wStrb_q);
   assign wrOne = wrGo && wrOk && awAddr_q == tcc_pkg::OFS_CTRL_ONE;
   assign wrTwo = wrGo && wrOk && awAddr_q == tcc_pkg::OFS_CTRL_TWO;
   assign wrArr = wrGo && wrOk && awAddr_q == tcc_pkg::OFS_ARR;
   assign wrEvt = wrGo && wrOk && awAddr_q == tcc_pkg::OFS_EVENT;

   always_ff @(posedge clock) begin
      if (srst) begin
         awHeld_q      <= 1'b0;
         wHeld_q       <= 1'b0;
         awAddr_q      <= 8'h00;
         wData_q       <= 32'h0000_0000;
         wStrb_q       <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= tcc_pkg::RESP_OKAY;
      end else begin
         s_axi_awready <= !awHeld_q && !s_axi_awready && s_axi_awvalid;
         s_axi_wready  <= !wHeld_q && !s_axi_wready && s_axi_wvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            awHeld_q <= 1'b1;
            awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
         end
         if (s_axi_wvalid && s_axi_wready) begin
            wHeld_q <= 1'b1;
            wData_q <= s_axi_wdata;
            wStrb_q <= s_axi_wstrb;
         end
         if (wrGo) begin
            awHeld_q     <= 1'b0;
            wHeld_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wrOne || wrTwo || wrArr || wrEvt) ?
                            tcc_pkg::RESP_OKAY : tcc_pkg::RESP_SLVERR;
         end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // read channel
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= tcc_pkg::RESP_OKAY;
      end else begin
         s_axi_arready <= !s_axi_rvalid && !s_axi_arready && s_axi_arvalid;
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp  <= tcc_pkg::RESP_OKAY;
            case (s_axi_araddr[7:2])
               6'h00:   s_axi_rdata <= {22'h0, ctlOne_q};
               6'h01:   s_axi_rdata <= {24'h0, ctlTwo_q, 3'b000};
               6'h02:   s_axi_rdata <= {16'h0, arrPre_q};
               6'h03:   s_axi_rdata <= 32'h0000_0000;
               6'h04:   s_axi_rdata <= {{(32-CNT_WIDTH){1'b0}}, cnt_q};
               default: begin
                  s_axi_rdata <= 32'h0000_0000;
                  s_axi_rresp <= tcc_pkg::RESP_SLVERR;
               end
            endcase
         end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // control registers
   // ----------------------------------------------------------------
   assign centreMode  = ctlOne_q.centre_align_select != 2'b00;
   assign readOnlyDir = centreMode || slaveMode == tcc_pkg::SLV_ENC1 ||
                        slaveMode == tcc_pkg::SLV_ENC2 ||
                        slaveMode == tcc_pkg::SLV_ENC3;
   assign swUpdate    = wrEvt && wData_q[tcc_pkg::F_UG] && wStrb_q[0];
   assign trigRise    = trigSync2_q && !trigPrev_q;
   // masked merges keep reserved bits zero
   assign oneMerged   = merge16({6'h00, ctlOne_q}, wData_q, wStrb_q,
                                tcc_pkg::CTRL_ONE_MASK);
   assign twoMerged   = merge16({8'h00, ctlTwo_q, 3'b000}, wData_q, wStrb_q,
                                tcc_pkg::CTRL_TWO_MASK);

   always_ff @(posedge clock) begin
      if (srst) begin
         ctlOne_q <= tcc_pkg::CTRL_ONE_RESET[9:0];
      end else begin
         if (wrOne) begin
            ctlOne_q <= oneMerged[9:0];
            if (readOnlyDir) ctlOne_q.dir <= downNow_q;
         end else if (readOnlyDir) begin
            ctlOne_q.dir <= downNow_q;
         end
         if (slaveMode == tcc_pkg::SLV_TRIGGER && trigRise)
            ctlOne_q.run <= 1'b1;
         if (ctlOne_q.spul && rawUpdate)
            ctlOne_q.run <= 1'b0;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         ctlTwo_q <= tcc_pkg::CTRL_TWO_RESET[7:3];
      end else if (wrTwo) begin
         ctlTwo_q <= twoMerged[7:3];
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         arrPre_q    <= tcc_pkg::ARR_RESET;
         arrShadow_q <= tcc_pkg::ARR_RESET;
      end else begin
         if (wrArr)
            arrPre_q <= merge16(arrPre_q, wData_q, wStrb_q, 16'hFFFF);
         if (wrArr && !ctlOne_q.reload_buffer_enable)
            arrShadow_q <= merge16(arrPre_q, wData_q, wStrb_q, 16'hFFFF);
         else if (updateEvent)
            arrShadow_q <= arrPre_q;
      end
   end

   // ----------------------------------------------------------------
   // pin sync, filter tick, input one
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         pinSync1_q  <= 3'b000;
         pinSync2_q  <= 3'b000;
         trigSync1_q <= 1'b0;
         trigSync2_q <= 1'b0;
         trigPrev_q  <= 1'b0;
      end else begin
         pinSync1_q  <= chPin;
         pinSync2_q  <= pinSync1_q;
         trigSync1_q <= triggerInput;
         trigSync2_q <= trigSync1_q;
         trigPrev_q  <= trigSync2_q;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) timerInputOne <= 1'b0;
      else if (ctlTwo_q.input_one_xor_select) timerInputOne <= ^pinSync2_q;
      else timerInputOne <= pinSync2_q[0];
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         divCnt_q   <= 2'b00;
         filterTick <= 1'b0;
      end else begin
         divCnt_q <= divCnt_q + 2'b01;
         case (ctlOne_q.filter_clock_divide)
            2'b00:   filterTick <= 1'b1;
            2'b01:   filterTick <= divCnt_q[0];
            2'b10:   filterTick <= divCnt_q == 2'b11;
            default: filterTick <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // counter, direction, update
   // ----------------------------------------------------------------
   // enable needs run; gated needs trigger high
   assign cntStep = ctlOne_q.run &&
                    (slaveMode != tcc_pkg::SLV_GATED || trigSync2_q);
   assign overflow = cntStep &&
      (downNow_q ? cnt_q == '0 : cnt_q == CNT_WIDTH'(arrShadow_q));
   assign rawUpdate = !ctlOne_q.uinh && (overflow || swUpdate || slaveUpdate);

   always_ff @(posedge clock) begin
      if (srst) begin
         cnt_q     <= '0;
         downNow_q <= 1'b0;
      end else if (swUpdate || slaveUpdate) begin
         cnt_q <= downNow_q ? CNT_WIDTH'(arrShadow_q) : '0;
      end else if (cntStep) begin
         if (centreMode) begin
            if (!downNow_q && cnt_q == CNT_WIDTH'(arrShadow_q)) begin
               downNow_q <= 1'b1;
               cnt_q     <= cnt_q - 1'b1;
            end else if (downNow_q && cnt_q == '0) begin
               downNow_q <= 1'b0;
               cnt_q     <= cnt_q + 1'b1;
            end else begin
               cnt_q <= downNow_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
            end
         end else begin
            downNow_q <= ctlOne_q.dir;
            if (overflow)
               cnt_q <= downNow_q ? CNT_WIDTH'(arrShadow_q) : '0;
            else
               cnt_q <= downNow_q ? cnt_q - 1'b1 : cnt_q + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // event outputs
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         updateEvent         <= 1'b0;
         updateRequest       <= 1'b0;
         chanRequest         <= 1'b0;
         ugPulse_q           <= 1'b0;
         counterEnableSignal <= 1'b0;
         counterValue        <= '0;
         compareFlagEnable   <= 1'b0;
         trigDly_q           <= 1'b0;
      end else begin
         updateEvent <= rawUpdate;
         updateRequest <= !ctlOne_q.uinh &&
                          (ctlOne_q.usrc ? overflow : rawUpdate);
         chanRequest <= ctlTwo_q.channel_request_timing ? rawUpdate : chan.cc1Event;
         ugPulse_q <= swUpdate || slaveUpdate;
         counterEnableSignal <= ctlOne_q.run ||
            (slaveMode == tcc_pkg::SLV_GATED && trigSync2_q);
         trigDly_q <= counterEnableSignal;
         counterValue <= cnt_q;
         case (ctlOne_q.centre_align_select)
            2'b01:   compareFlagEnable <= downNow_q;
            2'b10:   compareFlagEnable <= !downNow_q;
            default: compareFlagEnable <= 1'b1;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // trigger output mux
   // ----------------------------------------------------------------
   always_ff @(posedge clock) begin
      if (srst) begin
         triggerOutput <= 1'b0;
      end else begin
         case (ctlTwo_q.master_output_select)
            tcc_pkg::MMS_RESET:  triggerOutput <= ugPulse_q;
            tcc_pkg::MMS_ENABLE: triggerOutput <= masterSlaveSync ?
               counterEnableSignal : trigDly_q;
            tcc_pkg::MMS_UPDATE: triggerOutput <= updateEvent;
            tcc_pkg::MMS_PULSE:  triggerOutput <= chan.cc1Event;
            tcc_pkg::MMS_OC1:    triggerOutput <= chan.ocRef[0];
            tcc_pkg::MMS_OC2:    triggerOutput <= chan.ocRef[1];
            tcc_pkg::MMS_OC3:    triggerOutput <= chan.ocRef[2];
            tcc_pkg::MMS_OC4:    triggerOutput <= chan.ocRef[3];
            default:             triggerOutput <= 1'b0;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   property p_spul;
      @(posedge clock) disable iff (srst)
      ctlOne_q.spul && rawUpdate && !wrOne |=> !ctlOne_q.run;
   endproperty
   a_spul: assert property (p_spul) else $error("run kept after pulse");

   property p_inhibit;
      @(posedge clock) disable iff (srst)
      ctlOne_q.uinh |=> !updateEvent;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("update inhibited");

   property p_mms_upd;
      @(posedge clock) disable iff (srst)
      ctlTwo_q.master_output_select == tcc_pkg::MMS_UPDATE && $stable(ctlTwo_q)
         |=> triggerOutput == $past(updateEvent);
   endproperty
   a_mms_upd: assert property (p_mms_upd) else $error("mms update");

   property p_mms_oc;
      @(posedge clock) disable iff (srst)
      ctlTwo_q.master_output_select == tcc_pkg::MMS_OC2 |=> triggerOutput == $past(chan.ocRef[1]);
   endproperty
   a_mms_oc: assert property (p_mms_oc) else $error("mms oc2");

   property p_mms_ug;
      @(posedge clock) disable iff (srst)
      swUpdate && ctlTwo_q.master_output_select == tcc_pkg::MMS_RESET && !wrTwo ##1
      ctlTwo_q.master_output_select == tcc_pkg::MMS_RESET |=> triggerOutput;
   endproperty
   a_mms_ug: assert property (p_mms_ug) else $error("mms reset");

   property p_res_one;
      @(posedge clock) disable iff (srst)
      s_axi_arvalid && s_axi_arready && s_axi_araddr[7:2] == 6'h00
         |=> s_axi_rdata[15:10] == 6'h00;
   endproperty
   a_res_one: assert property (p_res_one) else $error("reserved set");

   property p_gated;
      @(posedge clock) disable iff (srst)
      slaveMode == tcc_pkg::SLV_GATED && !trigSync2_q && !swUpdate &&
      !slaveUpdate |=> $stable(cnt_q);
   endproperty
   a_gated: assert property (p_gated) else $error("gated count");

   property p_trig;
      @(posedge clock) disable iff (srst)
      slaveMode == tcc_pkg::SLV_TRIGGER && trigRise && !updateEvent
         |=> ctlOne_q.run;
   endproperty
   a_trig: assert property (p_trig) else $error("trigger start");

   property p_channel_request_timing;
      @(posedge clock) disable iff (srst)
      ctlTwo_q.channel_request_timing && !rawUpdate |=> !chanRequest;
   endproperty
   a_channel_request_timing: assert property (p_channel_request_timing) else $error("request timing");

   c_update: cover property (@(posedge clock) updateEvent);
   c_centre: cover property (@(posedge clock) centreMode && downNow_q);
   c_trigger_output: cover property (@(posedge clock) triggerOutput);

endmodule // tcc_timer_control

`default_nettype wire

// *** sim/tcc_slave_model.sv ***
// far-side model: a slave timer clocked by trigger output edges
// assumes the same clock as the timer control block
`timescale 1ns/1ps
`default_nettype none
module tcc_slave_model (
   // clock and reset
   input  wire logic clock,
   input  wire logic srst,
   // trigger from master
   input  wire logic trig,
   output var  int   edges
);
   logic trigQ;
   // counts rising edges like external clock mode
   always_ff @(posedge clock) begin
      trigQ <= trig;
      if (srst) edges <= 0;
      else if (trig && !trigQ) edges <= edges + 1;
   end
endmodule // tcc_slave_model
`default_nettype wire

// *** sim/tcc_timer_control_tb.sv ***
// bench for the timer control block and its slave timer model
// assumes design files under src and the slave model compiled first
`timescale 1ns/1ps
`default_nettype none
module tcc_timer_control_tb;
   logic clock, srst, awV, wV, bR, arV, rR, trgIn, msSync, slvUpd;
   logic [7:0] awA, arA;
   logic [31:0] wD;
   logic [3:0] wS;
   logic [2:0] chPin;
   logic [1:0] r;
   tcc_pkg::tcc_chan_t chan;
   tcc_pkg::tcc_slave_t slvMode;
   wire awRdy, wRdy, bV, arRdy, rV, trgOut, tiOne, fTick, updEv;
   wire cntEn, uReq, cReq, cfe;
   wire [15:0] cntV;
   wire [1:0] bResp, rResp;
   wire [31:0] rD;
   int err_total, checks, upd, edges, ureq;
   tcc_timer_control dut (.clock(clock), .srst(srst),
      .s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy),
      .s_axi_wdata(wD), .s_axi_wstrb(wS), .s_axi_wvalid(wV),
      .s_axi_wready(wRdy), .s_axi_bresp(bResp), .s_axi_bvalid(bV),
      .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
      .s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rResp),
      .s_axi_rvalid(rV), .s_axi_rready(rR), .chPin(chPin), .chan(chan),
      .slaveMode(slvMode), .triggerInput(trgIn),
      .masterSlaveSync(msSync), .slaveUpdate(slvUpd),
      .triggerOutput(trgOut), .timerInputOne(tiOne), .filterTick(fTick),
      .counterEnableSignal(cntEn), .counterValue(cntV), .updateEvent(updEv),
      .updateRequest(uReq), .chanRequest(cReq), .compareFlagEnable(cfe));
   tcc_slave_model slave (.clock(clock), .srst(srst), .trig(trgOut),
      .edges(edges));
   always @(posedge clock) if (updEv) upd++;
   always @(posedge clock) if (uReq) ureq++;
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d errors=%0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
      int n;
      @(posedge clock);
      awA <= a; wD <= d; wS <= s;
      awV <= 1'b1; wV <= 1'b1; bR <= 1'b1;
      for (n = 0; n < 60 && !bV; n++) begin
         @(posedge clock);
         if (awRdy) awV <= 1'b0;
         if (wRdy) wV <= 1'b0;
      end
      r = bResp;
      bR <= 1'b0;
      if (n == 60) begin err_total++; tally_and_finish(); end
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge clock);
      arA <= a; arV <= 1'b1; rR <= 1'b1;
      for (n = 0; n < 60 && !rV; n++) begin
         @(posedge clock);
         if (arRdy) arV <= 1'b0;
      end
      d = rD;
      r = rResp;
      rR <= 1'b0;
      if (n == 60) begin err_total++; tally_and_finish(); end
   endtask
   task automatic t_regs;
      logic [31:0] d;
      rd(8'h00, d); chk(d, 32'h0000);
      rd(8'h08, d); chk(d, 32'hFFFF);
      wr(8'h00, 32'hFF8E, 4'hF);
      rd(8'h00, d); chk(d, 32'h038E);
      wr(8'h04, 32'hFFFF, 4'hF);
      rd(8'h04, d); chk(d, 32'h00F8);
      wr(8'h04, 32'h0010, 4'h3); chk(r, tcc_pkg::RESP_OKAY);
      wr(8'h04, 32'h0020, 4'h1); chk(r, tcc_pkg::RESP_SLVERR);
      rd(8'h04, d); chk(d, 32'h0010);
      rd(8'h20, d); chk(r, tcc_pkg::RESP_SLVERR);
      wr(8'h00, 32'h0000, 4'hF);
   endtask
   task automatic t_update;
      int m, e0, u0;
      for (m = 0; m < 5; m += 2) begin
         if (m == 4) wr(8'h00, 32'h0002, 4'hF);
         wr(8'h04, 32'h0020 & (m << 4), 4'hF);
         e0 = edges; u0 = upd;
         wr(8'h0C, 32'h0001, 4'hF);
         cyc(6);
         chk(upd - u0, m < 4);
         chk(edges - e0, 1);
      end
      wr(8'h00, 32'h0000, 4'hF);
   endtask
   task automatic t_misc;
      int k, n, c;
      for (k = 4; k < 8; k++) begin
         wr(8'h04, 32'(k << 4), 4'hF);
         chan.ocRef <= 4'(1 << (k - 4)); cyc(4); chk(trgOut, 1);
         chan.ocRef <= 4'h0; cyc(4); chk(trgOut, 0);
      end
      chPin <= 3'b010;
      wr(8'h04, 32'h0000, 4'hF); cyc(6); chk(tiOne, 0);
      wr(8'h04, 32'h0080, 4'hF); cyc(6); chk(tiOne, 1);
      for (k = 0; k < 3; k++) begin
         wr(8'h00, 32'(k << 8), 4'hF);
         cyc(4);
         c = 0;
         for (n = 0; n < 8; n++) begin @(posedge clock); c += fTick; end
         chk(c, 8 >> k);
      end
   endtask
   task automatic t_count;
      logic [31:0] d;
      int u0, q0;
      u0 = upd;
      q0 = ureq;
      wr(8'h08, 32'h0003, 4'hF);
      wr(8'h00, 32'h0019, 4'hF);
      cyc(20);
      rd(8'h00, d); chk(d, 32'h0018);
      rd(8'h10, d); chk(d, 32'h0003);
      chk(upd - u0, 1);
      chk(ureq - q0, 1);
      wr(8'h00, 32'h0090, 4'hF);
      wr(8'h08, 32'h0005, 4'hF);
      wr(8'h00, 32'h0099, 4'hF);
      cyc(20);
      rd(8'h10, d); chk(d, 32'h0003);
      wr(8'h0C, 32'h0001, 4'hF);
      cyc(4);
      chk(cntV, 32'h0005);
      u0 = upd;
      q0 = ureq;
      wr(8'h00, 32'h0004, 4'hF);
      wr(8'h0C, 32'h0001, 4'hF);
      cyc(4);
      chk(upd - u0, 1);
      chk(ureq - q0, 0);
      chk(cntEn, 0);
      // centre modes chosen only while stopped
      wr(8'h00, 32'h0020, 4'hF);
      cyc(3);
      chk(cfe, 1);
      rd(8'h00, d); chk(d, 32'h0030);
      wr(8'h00, 32'h0040, 4'hF);
      cyc(3);
      chk(cfe, 0);
      wr(8'h00, 32'h0000, 4'hF);
      chan.cc1Event <= 1'b1;
      wr(8'h04, 32'h0030, 4'hF);
      cyc(3);
      chk(cReq, 1);
      chk(trgOut, 1);
      wr(8'h04, 32'h0038, 4'hF);
      cyc(3);
      chk(cReq, 0);
      chan.cc1Event <= 1'b0;
      wr(8'h04, 32'h0010, 4'hF);
      slvMode <= tcc_pkg::SLV_GATED;
      trgIn <= 1'b1;
      cyc(8);
      chk(cntEn, 1);
      chk(trgOut, 1);
      trgIn <= 1'b0;
      cyc(8);
      chk(cntEn, 0);
      slvMode <= tcc_pkg::SLV_TRIGGER;
      trgIn <= 1'b1;
      cyc(8);
      rd(8'h00, d); chk(d[0], 1);
      slvMode <= tcc_pkg::SLV_GATED;
      trgIn <= 1'b0;
      cyc(8);
      rd(8'h10, d);
      cyc(4);
      chk(cntV, d);
      slvMode <= tcc_pkg::SLV_OFF;
      wr(8'h00, 32'h0000, 4'hF);
   endtask
   initial begin
      srst = 1'b1; awV = 1'b0; wV = 1'b0; bR = 1'b0; arV = 1'b0;
      rR = 1'b0; awA = 8'h00; arA = 8'h00; wD = 32'h0; wS = 4'hF;
      chPin = 3'b000; chan = '0; slvMode = tcc_pkg::SLV_OFF;
      trgIn = 1'b0; msSync = 1'b0; slvUpd = 1'b0;
      err_total = 0; checks = 0; upd = 0;
      repeat (6) @(posedge clock);
      srst <= 1'b0;
      t_regs();
      t_update();
      t_misc();
      t_count();
      tally_and_finish();
   end
endmodule // tcc_timer_control_tb
`default_nettype wire
